// [core/pin_mux_pkg.sv]
`default_nettype none

package pin_mux_pkg;

    localparam int           NUM_PINS  = 26;
    localparam int           SEL_W     = 4;
    localparam int           PIN_IDX_W = 5;

    // pin indices: port 0 bit n is n, port 1 bit n is 16 + n
    localparam logic [4:0]   PIN_P0_2  = 5'h02;
    localparam logic [4:0]   PIN_P0_4  = 5'h04;
    localparam logic [4:0]   PIN_P0_8  = 5'h08;
    localparam logic [4:0]   PIN_P0_9  = 5'h09;
    localparam logic [4:0]   PIN_P0_10 = 5'h0A;
    localparam logic [4:0]   PIN_P0_11 = 5'h0B;
    localparam logic [4:0]   PIN_P0_12 = 5'h0C;
    localparam logic [4:0]   PIN_P0_13 = 5'h0D;
    localparam logic [4:0]   PIN_P0_14 = 5'h0E;
    localparam logic [4:0]   PIN_P0_15 = 5'h0F;
    localparam logic [4:0]   PIN_P1_6  = 5'h16;
    localparam logic [4:0]   PIN_P1_7  = 5'h17;
    localparam logic [4:0]   PIN_P1_8  = 5'h18;

    localparam logic [3:0]   SEL_ANALOG = 4'h0;
    localparam logic [3:0]   SEL_F1     = 4'h1;
    localparam logic [3:0]   SEL_F2     = 4'h2;
    localparam logic [3:0]   SEL_F3     = 4'h3;
    localparam logic [3:0]   SEL_F4     = 4'h4;
    localparam logic [3:0]   SEL_F5     = 4'h5;
    localparam logic [3:0]   SEL_F6     = 4'h6;
    localparam logic [3:0]   SEL_F7     = 4'h7;
    localparam logic [3:0]   SEL_F8     = 4'h8;
    localparam logic [3:0]   SEL_F9     = 4'h9;

    localparam logic [3:0]   SEL_RESET_VAL    = 4'h0;
    localparam logic         PU_OFF_RESET_VAL = 1'b0;

    // pins that own an internal pull-up, and pins with a selection-zero function
    localparam logic [25:0]  PULLUP_PRESENT = 26'h3F003B4;
    localparam logic [25:0]  ANALOG_PRESENT = 26'h3FE03FF;

    typedef struct packed {
        logic       valid;
        logic [4:0] pin;
        logic [3:0] sel;
        logic       pu_off;
    } pin_cfg_wr_t;

    typedef struct packed {
        logic motor_pwm_ch0_high;
        logic motor_pwm_ch0_low;
        logic motor_pwm_ch1_high;
        logic motor_pwm_ch1_low;
        logic motor_pwm_ch2_high;
        logic motor_pwm_ch2_low;
        logic motor_pwm_ch3_high;
        logic serial_port_tx;
        logic spi_clk;
        logic spi_data_out;
        logic spi_chip_sel;
        logic i2c_scl_pull_low;
        logic i2c_sda_pull_low;
        logic timer0_chan0;
        logic timer0_chan0_oe;
        logic timer0_chan1;
        logic timer0_chan1_oe;
        logic timer1_chan0;
        logic timer1_chan0_oe;
        logic comparator0_result;
        logic comparator1_result;
        logic clock_probe_out;
        logic adc_trigger;
    } periph_out_t;

    typedef struct packed {
        logic       serial_port_rx;
        logic [2:0] hall_sensor_in;
        logic       motor_pwm_fault_in1;
        logic       i2c_scl_in;
        logic       i2c_sda_in;
        logic       timer0_chan0_in;
        logic       timer0_chan1_in;
        logic       timer1_chan0_in;
        logic       debug_wire_clk;
        logic       ext_reset_n;
    } periph_in_t;

    typedef struct packed {
        logic phase_a_high_drive;
        logic phase_a_low_drive;
        logic phase_b_high_drive;
        logic phase_b_low_drive;
        logic phase_c_high_drive;
        logic phase_c_low_drive;
    } gate_drive_t;

endpackage

`default_nettype wire

// [core/pin_sync2.sv]
`default_nettype none

module pin_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    input  wire logic [WIDTH-1:0] idle_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second stage; both start at the pin's idle level
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            meta_q <= idle_i;
            sync_o <= idle_i;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule // pin_sync2

`default_nettype wire

// [core/pin_function_mux.sv]
// Overview of operation
// - each pin selects function 0..9; 0 is analog/special, 1..9 are digital peripherals.
// - phase A high/low drives follow port 0 bits 10/11, same polarity.
// - phase B high/low drives follow port 0 bits 12/13, same polarity.
// - phase C high/low drives follow port 0 bits 14/15, same polarity.
// - every pin with a pull-up has a software disable; pull-up on until disabled.
// - port 1 bit 8: 1 debug clock, 2 hall 2, 3 pwm ch3 high, 4 serial tx.
// - port 0 bit 9: pwm ch0 high, rx, spi out, sda, timer0 ch1, adc trigger.
// - port 0 bit 8: comparator 0, fault 1, tx, spi clock, scl, timer0 ch0.
// - port 0 bit 4: hall 0, pwm ch1 low, rx, spi select, scl, timer1 ch0.
// - port 1 bit 6: comparator 1, hall 1, pwm ch2 low, tx, timer0 ch1, adc.
// - port 1 bit 7: comparator 0, hall 0, pwm ch2 high, rx, timer0 ch0, adc.
// - port 0 bit 8 is always external interrupt 6 and wake-up 2.
// - port 0 bit 9 is also wake-up 3, besides external interrupt 7.
// - selection 1 on port 0 bits 9 or 10 drives the clock probe out.
// - port 0 bit 2 is the active-low reset input until reselected.
`default_nettype none

module pin_function_mux (
    input  wire logic                        sys_clk_i,
    input  wire logic                        rst_n_i,
    input  wire pin_mux_pkg::pin_cfg_wr_t    cfg_wr_i,
    input  wire logic [25:0]                 gpio_out_i,
    input  wire logic [25:0]                 gpio_oe_i,
    input  wire pin_mux_pkg::periph_out_t    periph_i,
    input  wire logic [25:0]                 pad_in_i,
    output logic      [25:0]                 pad_out_o,
    output logic      [25:0]                 pad_oe_o,
    output logic      [25:0]                 pullup_en_o,
    output logic      [25:0]                 analog_sel_o,
    output logic      [25:0]                 gpio_in_o,
    output logic      [25:0][3:0]            pin_sel_o,
    output var pin_mux_pkg::periph_in_t      periph_o,
    output var pin_mux_pkg::gate_drive_t     gate_o,
    output logic                             ext_irq_line6_o,
    output logic                             ext_irq_line7_o,
    output logic                             wake_line2_o,
    output logic                             wake_line3_o
);

    logic [25:0]       pu_off_q;
    logic [25:0]       pad_sync;
    logic [25:0][1:0]  drv_d;
    pin_mux_pkg::periph_in_t periph_d;

    // per-pin selection and pull-up disable, written one pin at a time
    for (genvar i = 0; i < pin_mux_pkg::NUM_PINS; i++) begin : g_cfg
        always_ff @(posedge sys_clk_i) begin
            if (!rst_n_i) begin
                pin_sel_o[i] <= pin_mux_pkg::SEL_RESET_VAL;
                pu_off_q[i]  <= pin_mux_pkg::PU_OFF_RESET_VAL;
            end else if (cfg_wr_i.valid && cfg_wr_i.pin == 5'(i)) begin
                pin_sel_o[i] <= cfg_wr_i.sel;
                pu_off_q[i]  <= cfg_wr_i.pu_off;
            end
        end
    end

    // pads are asynchronous to the system clock; pulled-up pins start high so no false low follows reset
    pin_sync2 #(
        .WIDTH (26)
    ) u_pad_sync (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   (pad_in_i),
        .idle_i    (pin_mux_pkg::PULLUP_PRESENT),
        .sync_o    (pad_sync)
    );

    function automatic logic is_sel(input logic [25:0][3:0] s, input logic [4:0] pin, input logic [3:0] code);
        return s[pin] == code;
    endfunction

    // {oe, out} pairs for push-pull and open-drain drive
    function automatic logic [1:0] push(input logic v);
        return {1'b1, v};
    endfunction

    function automatic logic [1:0] od_low(input logic pull_low);
        return {pull_low, 1'b0};
    endfunction

    always_comb begin
        for (int i = 0; i < pin_mux_pkg::NUM_PINS; i++) begin
            drv_d[i] = {gpio_oe_i[i], gpio_out_i[i]};
            if (pin_mux_pkg::ANALOG_PRESENT[i] && pin_sel_o[i] == pin_mux_pkg::SEL_ANALOG) begin
                drv_d[i] = 2'h0;
            end
        end
        // port 0 bit 4
        unique case (pin_sel_o[pin_mux_pkg::PIN_P0_4])
            pin_mux_pkg::SEL_F2: drv_d[pin_mux_pkg::PIN_P0_4] = 2'h0;
            pin_mux_pkg::SEL_F3: drv_d[pin_mux_pkg::PIN_P0_4] = push(periph_i.motor_pwm_ch1_low);
            pin_mux_pkg::SEL_F4: drv_d[pin_mux_pkg::PIN_P0_4] = 2'h0;
            pin_mux_pkg::SEL_F5: drv_d[pin_mux_pkg::PIN_P0_4] = push(periph_i.spi_chip_sel);
            pin_mux_pkg::SEL_F6: drv_d[pin_mux_pkg::PIN_P0_4] = od_low(periph_i.i2c_scl_pull_low);
            pin_mux_pkg::SEL_F8: drv_d[pin_mux_pkg::PIN_P0_4] = {periph_i.timer1_chan0_oe, periph_i.timer1_chan0};
            default: ;
        endcase
        // port 0 bit 8
        unique case (pin_sel_o[pin_mux_pkg::PIN_P0_8])
            pin_mux_pkg::SEL_F1: drv_d[pin_mux_pkg::PIN_P0_8] = push(periph_i.comparator0_result);
            pin_mux_pkg::SEL_F3: drv_d[pin_mux_pkg::PIN_P0_8] = 2'h0;
            pin_mux_pkg::SEL_F4: drv_d[pin_mux_pkg::PIN_P0_8] = push(periph_i.serial_port_tx);
            pin_mux_pkg::SEL_F5: drv_d[pin_mux_pkg::PIN_P0_8] = push(periph_i.spi_clk);
            pin_mux_pkg::SEL_F6: drv_d[pin_mux_pkg::PIN_P0_8] = od_low(periph_i.i2c_scl_pull_low);
            pin_mux_pkg::SEL_F7: drv_d[pin_mux_pkg::PIN_P0_8] = {periph_i.timer0_chan0_oe, periph_i.timer0_chan0};
            default: ;
        endcase
        // port 0 bit 9
        unique case (pin_sel_o[pin_mux_pkg::PIN_P0_9])
            pin_mux_pkg::SEL_F1: drv_d[pin_mux_pkg::PIN_P0_9] = push(periph_i.clock_probe_out);
            pin_mux_pkg::SEL_F3: drv_d[pin_mux_pkg::PIN_P0_9] = push(periph_i.motor_pwm_ch0_high);
            pin_mux_pkg::SEL_F4: drv_d[pin_mux_pkg::PIN_P0_9] = 2'h0;
            pin_mux_pkg::SEL_F5: drv_d[pin_mux_pkg::PIN_P0_9] = push(periph_i.spi_data_out);
            pin_mux_pkg::SEL_F6: drv_d[pin_mux_pkg::PIN_P0_9] = od_low(periph_i.i2c_sda_pull_low);
            pin_mux_pkg::SEL_F7: drv_d[pin_mux_pkg::PIN_P0_9] = {periph_i.timer0_chan1_oe, periph_i.timer0_chan1};
            pin_mux_pkg::SEL_F9: drv_d[pin_mux_pkg::PIN_P0_9] = push(periph_i.adc_trigger);
            default: ;
        endcase
        // port 0 bit 10
        unique case (pin_sel_o[pin_mux_pkg::PIN_P0_10])
            pin_mux_pkg::SEL_F1: drv_d[pin_mux_pkg::PIN_P0_10] = push(periph_i.clock_probe_out);
            pin_mux_pkg::SEL_F3: drv_d[pin_mux_pkg::PIN_P0_10] = push(periph_i.motor_pwm_ch0_high);
            pin_mux_pkg::SEL_F7: drv_d[pin_mux_pkg::PIN_P0_10] = {periph_i.timer0_chan0_oe, periph_i.timer0_chan0};
            pin_mux_pkg::SEL_F8: drv_d[pin_mux_pkg::PIN_P0_10] = {periph_i.timer1_chan0_oe, periph_i.timer1_chan0};
            default: ;
        endcase
        // gate-driver bits carry the pwm pairs on selection 3
        if (is_sel(pin_sel_o, pin_mux_pkg::PIN_P0_11, pin_mux_pkg::SEL_F3)) begin
            drv_d[pin_mux_pkg::PIN_P0_11] = push(periph_i.motor_pwm_ch0_low);
        end
        if (is_sel(pin_sel_o, pin_mux_pkg::PIN_P0_12, pin_mux_pkg::SEL_F3)) begin
            drv_d[pin_mux_pkg::PIN_P0_12] = push(periph_i.motor_pwm_ch1_high);
        end
        if (is_sel(pin_sel_o, pin_mux_pkg::PIN_P0_13, pin_mux_pkg::SEL_F3)) begin
            drv_d[pin_mux_pkg::PIN_P0_13] = push(periph_i.motor_pwm_ch1_low);
        end
        if (is_sel(pin_sel_o, pin_mux_pkg::PIN_P0_14, pin_mux_pkg::SEL_F3)) begin
            drv_d[pin_mux_pkg::PIN_P0_14] = push(periph_i.motor_pwm_ch2_high);
        end
        if (is_sel(pin_sel_o, pin_mux_pkg::PIN_P0_15, pin_mux_pkg::SEL_F3)) begin
            drv_d[pin_mux_pkg::PIN_P0_15] = push(periph_i.motor_pwm_ch2_low);
        end
        // port 1 bit 6
        unique case (pin_sel_o[pin_mux_pkg::PIN_P1_6])
            pin_mux_pkg::SEL_F1: drv_d[pin_mux_pkg::PIN_P1_6] = push(periph_i.comparator1_result);
            pin_mux_pkg::SEL_F2: drv_d[pin_mux_pkg::PIN_P1_6] = 2'h0;
            pin_mux_pkg::SEL_F3: drv_d[pin_mux_pkg::PIN_P1_6] = push(periph_i.motor_pwm_ch2_low);
            pin_mux_pkg::SEL_F4: drv_d[pin_mux_pkg::PIN_P1_6] = push(periph_i.serial_port_tx);
            pin_mux_pkg::SEL_F7: drv_d[pin_mux_pkg::PIN_P1_6] = {periph_i.timer0_chan1_oe, periph_i.timer0_chan1};
            pin_mux_pkg::SEL_F9: drv_d[pin_mux_pkg::PIN_P1_6] = push(periph_i.adc_trigger);
            default: ;
        endcase
        // port 1 bit 7
        unique case (pin_sel_o[pin_mux_pkg::PIN_P1_7])
            pin_mux_pkg::SEL_F1: drv_d[pin_mux_pkg::PIN_P1_7] = push(periph_i.comparator0_result);
            pin_mux_pkg::SEL_F2: drv_d[pin_mux_pkg::PIN_P1_7] = 2'h0;
            pin_mux_pkg::SEL_F3: drv_d[pin_mux_pkg::PIN_P1_7] = push(periph_i.motor_pwm_ch2_high);
            pin_mux_pkg::SEL_F4: drv_d[pin_mux_pkg::PIN_P1_7] = 2'h0;
            pin_mux_pkg::SEL_F7: drv_d[pin_mux_pkg::PIN_P1_7] = {periph_i.timer0_chan0_oe, periph_i.timer0_chan0};
            pin_mux_pkg::SEL_F9: drv_d[pin_mux_pkg::PIN_P1_7] = push(periph_i.adc_trigger);
            default: ;
        endcase
        // port 1 bit 8
        unique case (pin_sel_o[pin_mux_pkg::PIN_P1_8])
            pin_mux_pkg::SEL_F1: drv_d[pin_mux_pkg::PIN_P1_8] = 2'h0;
            pin_mux_pkg::SEL_F2: drv_d[pin_mux_pkg::PIN_P1_8] = 2'h0;
            pin_mux_pkg::SEL_F3: drv_d[pin_mux_pkg::PIN_P1_8] = push(periph_i.motor_pwm_ch3_high);
            pin_mux_pkg::SEL_F4: drv_d[pin_mux_pkg::PIN_P1_8] = push(periph_i.serial_port_tx);
            default: ;
        endcase
    end

    // inputs toward peripherals; several pins may share one input, idle level otherwise
    always_comb begin
        periph_d.serial_port_rx =
            (is_sel(pin_sel_o, pin_mux_pkg::PIN_P0_4, pin_mux_pkg::SEL_F4) ? pad_sync[pin_mux_pkg::PIN_P0_4] : 1'b1) &
            (is_sel(pin_sel_o, pin_mux_pkg::PIN_P0_9, pin_mux_pkg::SEL_F4) ? pad_sync[pin_mux_pkg::PIN_P0_9] : 1'b1) &
            (is_sel(pin_sel_o, pin_mux_pkg::PIN_P1_7, pin_mux_pkg::SEL_F4) ? pad_sync[pin_mux_pkg::PIN_P1_7] : 1'b1);
        periph_d.hall_sensor_in[0] =
            (is_sel(pin_sel_o, pin_mux_pkg::PIN_P0_4, pin_mux_pkg::SEL_F2) & pad_sync[pin_mux_pkg::PIN_P0_4]) |
            (is_sel(pin_sel_o, pin_mux_pkg::PIN_P1_7, pin_mux_pkg::SEL_F2) & pad_sync[pin_mux_pkg::PIN_P1_7]);
        periph_d.hall_sensor_in[1] =
            is_sel(pin_sel_o, pin_mux_pkg::PIN_P1_6, pin_mux_pkg::SEL_F2) & pad_sync[pin_mux_pkg::PIN_P1_6];
        periph_d.hall_sensor_in[2] =
            is_sel(pin_sel_o, pin_mux_pkg::PIN_P1_8, pin_mux_pkg::SEL_F2) & pad_sync[pin_mux_pkg::PIN_P1_8];
        periph_d.motor_pwm_fault_in1 =
            is_sel(pin_sel_o, pin_mux_pkg::PIN_P0_8, pin_mux_pkg::SEL_F3) & pad_sync[pin_mux_pkg::PIN_P0_8];
        periph_d.i2c_scl_in =
            (is_sel(pin_sel_o, pin_mux_pkg::PIN_P0_4, pin_mux_pkg::SEL_F6) ? pad_sync[pin_mux_pkg::PIN_P0_4] : 1'b1) &
            (is_sel(pin_sel_o, pin_mux_pkg::PIN_P0_8, pin_mux_pkg::SEL_F6) ? pad_sync[pin_mux_pkg::PIN_P0_8] : 1'b1);
        periph_d.i2c_sda_in =
            is_sel(pin_sel_o, pin_mux_pkg::PIN_P0_9, pin_mux_pkg::SEL_F6) ? pad_sync[pin_mux_pkg::PIN_P0_9] : 1'b1;
        periph_d.timer0_chan0_in =
            (is_sel(pin_sel_o, pin_mux_pkg::PIN_P0_8, pin_mux_pkg::SEL_F7) & pad_sync[pin_mux_pkg::PIN_P0_8]) |
            (is_sel(pin_sel_o, pin_mux_pkg::PIN_P0_10, pin_mux_pkg::SEL_F7) & pad_sync[pin_mux_pkg::PIN_P0_10]) |
            (is_sel(pin_sel_o, pin_mux_pkg::PIN_P1_7, pin_mux_pkg::SEL_F7) & pad_sync[pin_mux_pkg::PIN_P1_7]);
        periph_d.timer0_chan1_in =
            (is_sel(pin_sel_o, pin_mux_pkg::PIN_P0_9, pin_mux_pkg::SEL_F7) & pad_sync[pin_mux_pkg::PIN_P0_9]) |
            (is_sel(pin_sel_o, pin_mux_pkg::PIN_P1_6, pin_mux_pkg::SEL_F7) & pad_sync[pin_mux_pkg::PIN_P1_6]);
        periph_d.timer1_chan0_in =
            (is_sel(pin_sel_o, pin_mux_pkg::PIN_P0_4, pin_mux_pkg::SEL_F8) & pad_sync[pin_mux_pkg::PIN_P0_4]) |
            (is_sel(pin_sel_o, pin_mux_pkg::PIN_P0_10, pin_mux_pkg::SEL_F8) & pad_sync[pin_mux_pkg::PIN_P0_10]);
        periph_d.debug_wire_clk =
            is_sel(pin_sel_o, pin_mux_pkg::PIN_P1_8, pin_mux_pkg::SEL_F1) & pad_sync[pin_mux_pkg::PIN_P1_8];
        // reset pin starts selected; its synchroniser starts pulled up, so no reset pulse follows reset
        periph_d.ext_reset_n =
            is_sel(pin_sel_o, pin_mux_pkg::PIN_P0_2, pin_mux_pkg::SEL_ANALOG) ? pad_sync[pin_mux_pkg::PIN_P0_2] : 1'b1;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pad_out_o <= '0;
            pad_oe_o  <= '0;
        end else begin
            for (int i = 0; i < pin_mux_pkg::NUM_PINS; i++) begin
                pad_out_o[i] <= drv_d[i][0];
                pad_oe_o[i]  <= drv_d[i][1];
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            periph_o <= '{serial_port_rx: 1'b1, i2c_scl_in: 1'b1, i2c_sda_in: 1'b1, ext_reset_n: 1'b1, default: '0};
        end else begin
            periph_o <= periph_d;
        end
    end

    // gate drives track the port bit level in the same cycle as the pad itself
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            gate_o <= '0;
        end else begin
            gate_o.phase_a_high_drive <= drv_d[pin_mux_pkg::PIN_P0_10][0];
            gate_o.phase_a_low_drive  <= drv_d[pin_mux_pkg::PIN_P0_11][0];
            gate_o.phase_b_high_drive <= drv_d[pin_mux_pkg::PIN_P0_12][0];
            gate_o.phase_b_low_drive  <= drv_d[pin_mux_pkg::PIN_P0_13][0];
            gate_o.phase_c_high_drive <= drv_d[pin_mux_pkg::PIN_P0_14][0];
            gate_o.phase_c_low_drive  <= drv_d[pin_mux_pkg::PIN_P0_15][0];
        end
    end

    // interrupt and wake lines ignore the selection so a pin can wake from any function
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ext_irq_line6_o <= 1'b0;
            ext_irq_line7_o <= 1'b0;
            wake_line2_o    <= 1'b0;
            wake_line3_o    <= 1'b0;
            gpio_in_o       <= '0;
        end else begin
            ext_irq_line6_o <= pad_sync[pin_mux_pkg::PIN_P0_8];
            wake_line2_o    <= pad_sync[pin_mux_pkg::PIN_P0_8];
            ext_irq_line7_o <= pad_sync[pin_mux_pkg::PIN_P0_9];
            wake_line3_o    <= pad_sync[pin_mux_pkg::PIN_P0_9];
            gpio_in_o       <= pad_sync;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pullup_en_o  <= pin_mux_pkg::PULLUP_PRESENT;
            analog_sel_o <= pin_mux_pkg::ANALOG_PRESENT;
        end else begin
            for (int i = 0; i < pin_mux_pkg::NUM_PINS; i++) begin
                pullup_en_o[i]  <= pin_mux_pkg::PULLUP_PRESENT[i] & ~pu_off_q[i];
                analog_sel_o[i] <= pin_mux_pkg::ANALOG_PRESENT[i] &
                                   (pin_sel_o[i] == pin_mux_pkg::SEL_ANALOG);
            end
        end
    end

endmodule // pin_function_mux

`default_nettype wire

// [dv/pin_mux_properties.sv]
`default_nettype none
module pin_mux_properties (
    input wire logic                     sys_clk_i,
    input wire logic                     rst_n_i,
    input wire pin_mux_pkg::pin_cfg_wr_t cfg_wr_i,
    input wire pin_mux_pkg::periph_out_t periph_i,
    input wire logic [25:0]              pad_in_i,
    input wire logic [25:0]              pad_out_o,
    input wire logic [25:0]              pad_oe_o,
    input wire logic [25:0]              pullup_en_o,
    input wire logic [25:0][3:0]         pin_sel_o,
    input wire pin_mux_pkg::gate_drive_t gate_o,
    input wire logic                     ext_irq_line6_o,
    input wire logic                     ext_irq_line7_o,
    input wire logic                     wake_line2_o,
    input wire logic                     wake_line3_o
);
    // pad paths only carry real pad history three edges after reset ends
    logic [1:0] up_q;
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) up_q <= 2'h0;
        else if (up_q != 2'h3) up_q <= up_q + 2'h1;
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_phase_a_drive: assert property (gate_o[5:4] == {pad_out_o[10], pad_out_o[11]})
        else $error("phase a drive differs from its port bits");
    chk_phase_b_drive: assert property (gate_o[3:2] == {pad_out_o[12], pad_out_o[13]})
        else $error("phase b drive differs from its port bits");
    chk_phase_c_drive: assert property (gate_o[1:0] == {pad_out_o[14], pad_out_o[15]})
        else $error("phase c drive differs from its port bits");
    chk_p08_lines: assert property (&up_q |-> {ext_irq_line6_o, wake_line2_o} == {2{$past(pad_in_i[8], 3)}})
        else $error("port 0 bit 8 interrupt or wake line wrong");
    chk_p09_lines: assert property (&up_q |-> {ext_irq_line7_o, wake_line3_o} == {2{$past(pad_in_i[9], 3)}})
        else $error("port 0 bit 9 interrupt or wake line wrong");
    chk_sel_stored: assert property (cfg_wr_i.valid && cfg_wr_i.pin < 5'h1A
        |=> pin_sel_o[$past(cfg_wr_i.pin)] == $past(cfg_wr_i.sel)) else $error("pin selection not stored");
    chk_pwm_on_p09: assert property ($past(pin_sel_o[9]) == 4'h3 |-> pad_oe_o[9]
        && pad_out_o[9] == $past(periph_i.motor_pwm_ch0_high)) else $error("port 0 bit 9 pwm route wrong");
    chk_pullup_exists: assert property ((pullup_en_o & ~pin_mux_pkg::PULLUP_PRESENT) == 26'h0)
        else $error("pull-up reported on a pin without one");
endmodule // pin_mux_properties
bind pin_function_mux pin_mux_properties pin_mux_properties_i (.sys_clk_i, .rst_n_i, .cfg_wr_i, .periph_i, .pad_in_i,
    .pad_out_o, .pad_oe_o, .pullup_en_o, .pin_sel_o, .gate_o, .ext_irq_line6_o, .ext_irq_line7_o, .wake_line2_o,
    .wake_line3_o);
`default_nettype wire

// [dv/pin_board_model.sv]
`default_nettype none
module pin_board_model (
    input  wire logic [25:0] pad_out_i,
    input  wire logic [25:0] pad_oe_i,
    input  wire logic [25:0] pullup_en_i,
    input  wire logic [25:0] ext_val_i,
    input  wire logic [25:0] ext_en_i,
    output logic      [25:0] pad_level_o
);
    logic       pwm_output_exchange_ctrl;
    logic [7:0] analog_frontend_cfg_reg0;
    assign pwm_output_exchange_ctrl = 1'b0;
    assign analog_frontend_cfg_reg0 = 8'h20;
    // a pin nobody drives and without pull-up shows the inverse of its last output
    assign pad_level_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_en_i & ext_val_i)
        | (~pad_oe_i & ~ext_en_i & (pullup_en_i | ~pad_out_i));
endmodule // pin_board_model
`default_nettype wire

// [dv/pin_function_mux_bench.sv]
`default_nettype none
module pin_function_mux_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic                     sys_clk_i = 1'b0;
    logic                     rst_n_i = 1'b0;
    pin_mux_pkg::pin_cfg_wr_t cfg = '0;
    pin_mux_pkg::periph_out_t per = '0;
    pin_mux_pkg::periph_in_t  pin_in;
    pin_mux_pkg::gate_drive_t gate;
    logic [25:0][3:0]         sel_o;
    logic [25:0]              g_out = '0, g_oe = '0, x_val = '0, x_en = '0;
    logic [25:0]              p_out, p_oe, pu, ana, gin, pad;
    logic                     irq6, irq7, wk2, wk3;
    int                       miscompares = 0;
    int                       cmp_count = 0;
    always #2.5 sys_clk_i = ~sys_clk_i;
    pin_function_mux pin_function_mux_i (.sys_clk_i, .rst_n_i, .cfg_wr_i(cfg), .gpio_out_i(g_out), .gpio_oe_i(g_oe),
        .periph_i(per), .pad_in_i(pad), .pad_out_o(p_out), .pad_oe_o(p_oe), .pullup_en_o(pu), .analog_sel_o(ana),
        .gpio_in_o(gin), .pin_sel_o(sel_o), .periph_o(pin_in), .gate_o(gate), .ext_irq_line6_o(irq6),
        .ext_irq_line7_o(irq7), .wake_line2_o(wk2), .wake_line3_o(wk3));
    pin_board_model pin_board_model_i (.pad_out_i(p_out), .pad_oe_i(p_oe), .pullup_en_i(pu), .ext_val_i(x_val),
        .ext_en_i(x_en), .pad_level_o(pad));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wr(input logic [4:0] p, input logic [3:0] s, input logic off);
        @(posedge sys_clk_i);
        cfg <= '{1'b1, p, s, off};
        @(posedge sys_clk_i);
        cfg <= '0;
        cyc(2);
    endtask
    task automatic put_per(input logic [22:0] v);
        @(posedge sys_clk_i);
        per <= v;
        cyc(1);
    endtask
    task automatic t_reset();
        chk("pullup", pu, pin_mux_pkg::PULLUP_PRESENT);
        chk("analog", ana, pin_mux_pkg::ANALOG_PRESENT);
        chk("sel", sel_o[8], 4'h0);
        chk("idle in", {pin_in.serial_port_rx, pin_in.ext_reset_n}, 2'h3);
        $display("test reset done");
    endtask
    task automatic t_route();
        // pin * 10000 + selection * 100 + bit of the peripheral output word
        int t[24] = '{90101, 90322, 90513, 90707, 90900, 100101, 80103, 80415, 80514, 80709, 40319, 40512, 40805,
            220102, 220317, 220415, 220707, 220900, 230103, 230318, 230709, 230900, 240316, 240415};
        int p;
        foreach (t[k]) begin
            p = t[k] / 10000;
            wr(5'(p), 4'(t[k] / 100 % 100), 1'b0);
            put_per(23'h150 | (23'h1 << (t[k] % 100)));
            chk("route hi", {p_oe[p], p_out[p]}, 2'h3);
            put_per(23'h150);
            chk("route lo", p_out[p], 1'b0);
        end
        wr(5'h09, 4'h6, 1'b0);
        put_per(23'h400);
        chk("sda pull", {p_oe[9], p_out[9]}, 2'h2);
        put_per(23'h0);
        wr(5'h08, 4'hA, 1'b0);
        @(posedge sys_clk_i);
        g_oe <= 26'h100;
        g_out <= 26'h100;
        cyc(1);
        chk("plain gpio", {p_oe[8], p_out[8]}, 2'h3);
        $display("test route done");
    endtask
    task automatic t_gate();
        for (int i = 10; i < 16; i++) wr(5'(i), 4'h3, 1'b0);
        put_per(23'h520000);
        chk("gate", gate, 6'h29);
        put_per(23'h2C0000);
        chk("gate", gate, 6'h16);
        $display("test gate done");
    endtask
    task automatic t_inputs();
        wr(5'h08, 4'h3, 1'b0);
        wr(5'h18, 4'h2, 1'b0);
        wr(5'h04, 4'h4, 1'b0);
        @(posedge sys_clk_i);
        x_en <= 26'h1000314;
        x_val <= 26'h1000300;
        cyc(4);
        chk("fault", pin_in.motor_pwm_fault_in1, 1'b1);
        chk("hall2", pin_in.hall_sensor_in[2], 1'b1);
        chk("rx", pin_in.serial_port_rx, 1'b0);
        chk("rst pin", pin_in.ext_reset_n, 1'b0);
        chk("lines", {irq6, wk2, irq7, wk3, gin[9:8]}, 6'h3F);
        chk("analog off", ana[8], 1'b0);
        wr(5'h04, 4'h0, 1'b0);
        wr(5'h08, 4'h0, 1'b1);
        wr(5'h02, 4'h5, 1'b0);
        cyc(3);
        chk("idle", {pin_in.serial_port_rx, pin_in.motor_pwm_fault_in1, pin_in.ext_reset_n}, 3'h5);
        chk("pu off", pu[9:8], 2'h2);
        chk("analog on", {ana[8], irq6}, 2'h3);
        wr(5'h18, 4'h1, 1'b0);
        chk("debug clk", {pin_in.debug_wire_clk, pin_in.hall_sensor_in[2]}, 2'h2);
        $display("test inputs done");
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        cyc(5);
        t_reset();
        t_route();
        t_gate();
        t_inputs();
        tally_and_finish();
    end
    initial begin
        #20us;
        miscompares++;
        tally_and_finish();
    end
endmodule // pin_function_mux_bench
`default_nettype wire
